// File: hw/sass_count_decr.sv
// serial down-counter for the shift count held in the command register
`timescale 1ns/1ns
module sass_count_decr #(
  parameter int COUNT_W = sass_pkg::SASS_COUNT_BITS
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // sequencer side
  sass_count_if.counter cnt
);
  import sass_pkg::*;

  logic [COUNT_W-1:0] count;
  logic carry;

  // ------------------------------------------------------------------
  // serial borrow: carry inverts bits until the first one is seen
  // ------------------------------------------------------------------
  wire low_bit = count[0];
  wire next_bit = cnt.enable ? (low_bit ^ carry) : low_bit;

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      count <= '0;
      carry <= SASS_CARRY_RST;
    end
    else if (cnt.load)
    begin
      count <= cnt.load_value;
      carry <= SASS_CARRY_RST;
    end
    else if (cnt.sign_time)
    begin
      carry <= 1'b1;
    end
    else if (cnt.in_field)
    begin
      count <= {next_bit, count[COUNT_W-1:1]};
      if (low_bit)
      begin
        carry <= 1'b0;
      end
    end
  end

  // a carry still set at sign time means the count was zero
  assign cnt.carry = carry;
  assign cnt.count = count;

endmodule // sass_count_decr

// File: hw/sass_count_if.sv
// shift count decrement signals between sequencer and count register
`timescale 1ns/1ns
interface sass_count_if #(parameter int COUNT_W = 6);
  logic load;
  logic [COUNT_W-1:0] load_value;
  logic enable;
  logic sign_time;
  logic in_field;
  logic carry;
  logic [COUNT_W-1:0] count;

  modport seq (output load, output load_value, output enable, output sign_time, output in_field,
               input carry, input count);
  modport counter (input load, input load_value, input enable, input sign_time, input in_field,
                   output carry, output count);
endinterface

// File: hw/sass_pkg.sv
// shared constants and types for the serial accumulator shift sequencer
package sass_pkg;

  // ------------------------------------------------------------------
  // word framing and count field
  // ------------------------------------------------------------------
  localparam int SASS_WORD_BITS = 32;
  localparam int SASS_COUNT_BITS = 6;
  localparam int SASS_COUNT_LSB = 8;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic SASS_CARRY_RST = 1'b1;
  localparam logic SASS_FLAG_RST = 1'b0;
  localparam logic SASS_TRACK_RST = 1'b0;

  // ------------------------------------------------------------------
  // word-period sequence
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    SASS_IDLE = 4'h0,
    SASS_PH3 = 4'h1,
    SASS_WP1 = 4'h2,
    SASS_WP2 = 4'h3,
    SASS_WP3 = 4'h4,
    SASS_SHIFT = 4'h5,
    SASS_STOPF = 4'h6,
    SASS_STOPH = 4'h7,
    SASS_STOPG = 4'h8
  } sass_state_t;

endpackage

// File: hw/sass_shift_seq.sv
// shift command sequencer for the double-length serial accumulator
//
// Behaviour
// - shift right when the lowest data track bit is 0, left when 1
// - bit positions moved equal the count from the data sector field
// - operand search phase 3 ends after exactly one word period
// - phase 4 is word period 1; periods 1 and 2 same for both directions
// - odd/even flag cleared ending phase 4, set ending period 2, stays set
// - F and G cleared at sign time ending phase 4 unless repeat is on
// - F set again at the sign time closing word period 3
// - both accumulators recirculate unchanged during word period 1
// - from period 2 each sign time test trackers; left shift sets branch on overflow or minus one
// - word period 2 clears lower-shift and middle trackers, loads first with lower sign
// - left shift from period 3 passes upper through a delay, up one per word
// - below-half tracker set only from neighbour, cleared only at sign time
// - left shift passes lower through its own delay, up one per word
// - left sign time drops upper top bit; lower second bit enters upper bottom
// - lower-shift tracker cleared each sign time, inserting zero at lower bottom
// - count decremented serially each word of phase 4a with a carry flag
// - zero count keeps carry, sets G; then F, H, G cleared in turn
// - from period 2 each sign time checks overflow and zero count
// - right shift repeats upper sign; upper lowest bit enters lower top
// - zero count clears H before period 3 so nothing shifts
`timescale 1ns/1ns
module sass_shift_seq #(
  parameter int WORD_W = sass_pkg::SASS_WORD_BITS,
  parameter int COUNT_W = sass_pkg::SASS_COUNT_BITS,
  parameter int COUNT_LSB = sass_pkg::SASS_COUNT_LSB
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // accumulator preset
  input wire logic acc_load_in,
  input wire logic [WORD_W-1:0] upper_load_in,
  input wire logic [WORD_W-1:0] lower_load_in,
  // shift command
  input wire logic start_in,
  input wire logic shift_left_in,
  input wire logic [COUNT_W-1:0] shift_count_in,
  input wire logic repeat_in,
  // accumulator view
  output logic [WORD_W-1:0] upper_out,
  output logic [WORD_W-1:0] lower_out,
  // status
  output logic busy_out,
  output logic done_out,
  output logic branch_out,
  output logic sign_time_out,
  output logic phase_f_out,
  output logic phase_g_out,
  output logic phase_h_out,
  output logic odd_even_out,
  output logic [COUNT_W-1:0] count_out
);
  import sass_pkg::*;

  localparam int TIME_W = $clog2(WORD_W);
  localparam logic [TIME_W-1:0] LAST_BIT = TIME_W'(WORD_W - 1);
  localparam logic [TIME_W-1:0] PRE_LAST = TIME_W'(WORD_W - 2);
  localparam logic [TIME_W-1:0] FIELD_LO = TIME_W'(COUNT_LSB);
  localparam logic [TIME_W-1:0] FIELD_HI = TIME_W'(COUNT_LSB + COUNT_W - 1);

  // ------------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------------
  generate
    if (WORD_W < 8 || COUNT_W < 2 || COUNT_LSB + COUNT_W > WORD_W - 1)
    begin : g_bad_params
      $error("sass_shift_seq: unsupported word or count field size");
    end
  endgenerate

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  sass_state_t state;
  sass_state_t next_state;
  logic [TIME_W-1:0] bit_time;
  logic [WORD_W-1:0] upper;
  logic [WORD_W-1:0] lower;
  logic [WORD_W-1:0] upper_hold;
  logic [WORD_W-1:0] lower_hold;
  logic load_pending;
  logic start_pending;
  logic left;
  logic f;
  logic g;
  logic h;
  logic p1;
  logic p2;
  logic p3;
  logic p4;
  logic p5;
  logic next_f;
  logic next_g;
  logic next_h;
  logic next_p1;
  logic done_event;

  sass_count_if #(.COUNT_W(COUNT_W)) cif ();

  // ------------------------------------------------------------------
  // word framing
  // ------------------------------------------------------------------
  wire sign_time = (bit_time == LAST_BIT);
  wire in_field = (bit_time >= FIELD_LO) && (bit_time <= FIELD_HI);
  wire [TIME_W-1:0] next_bit_time = sign_time ? '0 : bit_time + TIME_W'(1);

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      bit_time <= '0;
    end
    else
    begin
      bit_time <= next_bit_time;
    end
  end

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire idle = (state == SASS_IDLE);
  wire in_wp2 = (state == SASS_WP2);
  wire shifting = (state == SASS_WP3) || (state == SASS_SHIFT);
  wire tracking = in_wp2 || shifting;
  wire phase_4a = tracking;
  wire zero_count = cif.carry;
  wire start_take = start_in && idle && !start_pending;
  wire load_take = acc_load_in && idle;
  wire load_apply = load_pending && sign_time;

  // ------------------------------------------------------------------
  // count register hookup
  // ------------------------------------------------------------------
  assign cif.load = start_take;
  assign cif.load_value = shift_count_in;
  assign cif.enable = phase_4a;
  assign cif.sign_time = sign_time;
  assign cif.in_field = in_field;

  sass_count_decr #(
    .COUNT_W(COUNT_W)
  ) u_count (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .cnt(cif.counter)
  );

  // ------------------------------------------------------------------
  // serial data path
  // ------------------------------------------------------------------
  // bit t of each word sits in position 0 at bit time t; new bits enter at the top
  wire upper_bit = upper[0];
  wire lower_bit = lower[0];

  // left: both words pass through a one-bit delay
  wire left_upper_bit = p3;
  wire left_lower_bit = p2;

  // right: read one bit early; sign repeats, upper lsb lands in lower top
  wire right_upper_bit = sign_time ? upper[0] : upper[1];
  wire right_lower_bit = sign_time ? p2 : lower[1];

  wire dir_upper_bit = left ? left_upper_bit : right_upper_bit;
  wire dir_lower_bit = left ? left_lower_bit : right_lower_bit;

  // outside the shifting periods everything recirculates
  wire next_upper_bit = shifting ? dir_upper_bit : upper_bit;
  wire next_lower_bit = shifting ? dir_lower_bit : lower_bit;

  wire [WORD_W-1:0] stream_upper = {next_upper_bit, upper[WORD_W-1:1]};
  wire [WORD_W-1:0] stream_lower = {next_lower_bit, lower[WORD_W-1:1]};
  wire [WORD_W-1:0] next_upper = load_apply ? upper_hold : stream_upper;
  wire [WORD_W-1:0] next_lower = load_apply ? lower_hold : stream_lower;

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      upper <= '0;
      lower <= '0;
    end
    else
    begin
      upper <= next_upper;
      lower <= next_lower;
    end
  end

  // ------------------------------------------------------------------
  // preset path
  // ------------------------------------------------------------------
  // a preset is held until a word boundary so the words stay bit-aligned
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      load_pending <= SASS_FLAG_RST;
      upper_hold <= '0;
      lower_hold <= '0;
    end
    else if (load_take)
    begin
      load_pending <= 1'b1;
      upper_hold <= upper_load_in;
      lower_hold <= lower_load_in;
    end
    else if (load_apply)
    begin
      load_pending <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // overflow tracking flip-flops
  // ------------------------------------------------------------------
  // p2 holds the upper lsb for a right shift, the lower delay for a left one
  wire right_p2 = (bit_time == '0) ? upper_bit : p2;
  wire left_p2 = sign_time ? 1'b0 : lower_bit;
  wire next_p2 = left ? left_p2 : right_p2;
  wire sign_p3 = in_wp2 ? lower_bit : p2;
  wire next_p3 = sign_time ? sign_p3 : upper_bit;
  wire next_p4 = sign_time ? 1'b0 : p3;
  wire next_p5 = sign_time ? 1'b0 : (p5 | p4);

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      p2 <= SASS_TRACK_RST;
      p3 <= SASS_TRACK_RST;
      p4 <= SASS_TRACK_RST;
      p5 <= SASS_TRACK_RST;
    end
    else if (tracking)
    begin
      p2 <= next_p2;
      p3 <= next_p3;
      p4 <= next_p4;
      p5 <= next_p5;
    end
  end

  // ------------------------------------------------------------------
  // overflow test
  // ------------------------------------------------------------------
  // trackers see the word before its shift, so this predicts the next shift;
  // with the count exhausted no further shift follows and nothing is flagged
  wire sign_split = (!p3 && p4) || (p3 && !p4);
  wire minus_one = p3 && p4 && !p5 && !lower_bit;
  wire overflow = left && tracking && sign_time && !zero_count && (sign_split || minus_one);

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      branch_out <= SASS_FLAG_RST;
    end
    else if (overflow)
    begin
      branch_out <= 1'b1;
    end
    else if (start_take)
    begin
      branch_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // phase sequencing, all steps at sign time
  // ------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_f = f;
    next_g = g;
    next_h = h;
    next_p1 = p1;
    done_event = 1'b0;
    if (sign_time)
    begin
      case (state)
        SASS_IDLE:
        begin
          if (start_pending)
          begin
            next_state = SASS_PH3;
            next_f = 1'b1;
            next_g = 1'b0;
            next_h = 1'b0;
          end
        end
        SASS_PH3:
        begin
          next_g = 1'b1;
          next_state = SASS_WP1;
        end
        SASS_WP1:
        begin
          // a repeated command holds phase 4
          if (!repeat_in)
          begin
            next_f = 1'b0;
            next_g = 1'b0;
            next_h = 1'b1;
            next_p1 = 1'b0;
            next_state = SASS_WP2;
          end
        end
        SASS_WP2:
        begin
          next_p1 = 1'b1;
          if (zero_count)
          begin
            next_h = 1'b0;
            next_state = SASS_IDLE;
            done_event = 1'b1;
          end
          else
          begin
            next_state = SASS_WP3;
          end
        end
        SASS_WP3:
        begin
          next_f = 1'b1;
          if (zero_count)
          begin
            next_g = 1'b1;
            next_state = SASS_STOPF;
          end
          else
          begin
            next_state = SASS_SHIFT;
          end
        end
        SASS_SHIFT:
        begin
          if (zero_count)
          begin
            next_g = 1'b1;
            next_state = SASS_STOPF;
          end
        end
        SASS_STOPF:
        begin
          next_f = 1'b0;
          next_state = SASS_STOPH;
        end
        SASS_STOPH:
        begin
          next_h = 1'b0;
          next_state = SASS_STOPG;
        end
        SASS_STOPG:
        begin
          next_g = 1'b0;
          next_state = SASS_IDLE;
          done_event = 1'b1;
        end
        default:
        begin
          next_state = SASS_IDLE;
          next_f = 1'b0;
          next_g = 1'b0;
          next_h = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      state <= SASS_IDLE;
      f <= SASS_FLAG_RST;
      g <= SASS_FLAG_RST;
      h <= SASS_FLAG_RST;
      p1 <= SASS_FLAG_RST;
    end
    else
    begin
      state <= next_state;
      f <= next_f;
      g <= next_g;
      h <= next_h;
      p1 <= next_p1;
    end
  end

  // ------------------------------------------------------------------
  // command capture
  // ------------------------------------------------------------------
  // a start waits for the next word boundary; a second start meanwhile is ignored
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      start_pending <= SASS_FLAG_RST;
      left <= SASS_FLAG_RST;
    end
    else if (start_take)
    begin
      start_pending <= 1'b1;
      left <= shift_left_in;
    end
    else if (idle && sign_time)
    begin
      start_pending <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      upper_out <= '0;
      lower_out <= '0;
      count_out <= '0;
      busy_out <= SASS_FLAG_RST;
      done_out <= SASS_FLAG_RST;
      sign_time_out <= SASS_FLAG_RST;
    end
    else
    begin
      // words are only whole and aligned at a boundary
      if (sign_time)
      begin
        upper_out <= next_upper;
        lower_out <= next_lower;
        count_out <= cif.count;
      end
      busy_out <= (next_state != SASS_IDLE) || start_take || (start_pending && !(idle && sign_time))
                  || (idle && sign_time && start_pending);
      done_out <= done_event;
      sign_time_out <= (bit_time == PRE_LAST);
    end
  end

  assign phase_f_out = f;
  assign phase_g_out = g;
  assign phase_h_out = h;
  assign odd_even_out = p1;

endmodule // sass_shift_seq

// File: test/sass_shift_seq_properties.sv
// port-level checks for the shift sequencer
`timescale 1ns/1ns
module sass_shift_seq_properties
  import sass_pkg::*;
#(
  parameter int WORD_W = SASS_WORD_BITS,
  parameter int COUNT_W = SASS_COUNT_BITS,
  parameter int COUNT_LSB = SASS_COUNT_LSB
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // command
  input wire logic repeat_in,
  // observed outputs
  input wire logic [WORD_W-1:0] upper_out,
  input wire logic [WORD_W-1:0] lower_out,
  input wire logic done_out,
  input wire logic branch_out,
  input wire logic sign_time_out,
  input wire logic phase_f_out,
  input wire logic phase_g_out,
  input wire logic phase_h_out,
  input wire logic odd_even_out,
  input wire logic [COUNT_W-1:0] count_out
);
  // ------------------------------------------------------------------
  // word-period decode
  // ------------------------------------------------------------------
  wire logic ph3 = phase_f_out & ~phase_g_out & ~phase_h_out;
  wire logic wp1 = phase_f_out & phase_g_out & ~phase_h_out;
  wire logic wp2 = ~phase_f_out & ~phase_g_out & phase_h_out & ~odd_even_out;
  wire logic stopg = ~phase_f_out & phase_g_out & ~phase_h_out;
  wire logic zero = (count_out == '0);

  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_sign_period: assert property (sign_time_out |-> ##32 sign_time_out)
    else $error("sign time period wrong");
  a_sign_single: assert property (sign_time_out |=> !sign_time_out [*8])
    else $error("sign time longer than one bit");
  a_phase_three: assert property (ph3 && sign_time_out |=> wp1)
    else $error("search phase not ended after one word");
  a_flops_at_sign: assert property ($changed({phase_f_out, phase_g_out, phase_h_out, odd_even_out})
    |-> $past(sign_time_out))
    else $error("phase flop moved off a word boundary");
  a_end_phase_four: assert property (wp1 && sign_time_out && !repeat_in
    |=> !phase_f_out && !phase_g_out && phase_h_out && !odd_even_out)
    else $error("phase 4 did not end into word period 2");
  a_repeat_hold: assert property (wp1 && sign_time_out && repeat_in |=> wp1)
    else $error("repeat did not hold phase 4");
  a_zero_skip: assert property (wp2 && sign_time_out && zero |=> !phase_h_out)
    else $error("zero count did not drop h");
  a_wp_three: assert property (wp2 && sign_time_out && !zero
    |=> !phase_f_out && phase_h_out && odd_even_out)
    else $error("word period 3 not entered with flag set");
  a_shift_word: assert property (phase_h_out && !phase_g_out && odd_even_out && sign_time_out
    |=> phase_f_out && phase_h_out && odd_even_out && (phase_g_out == $past(zero)))
    else $error("f or g wrong after a shift word");
  a_count_step: assert property (phase_h_out && !phase_g_out && sign_time_out && !(wp2 && zero)
    |=> count_out == COUNT_W'($past(count_out) - 1'b1))
    else $error("count not decremented by one");
  a_stop_order: assert property (phase_g_out && phase_h_out && sign_time_out
    |=> phase_g_out && !phase_f_out)
    else $error("stop sequence out of order");
  a_finish_done: assert property (stopg && sign_time_out |=> !phase_g_out && done_out ##1 !done_out)
    else $error("command did not finish with one done pulse");
  a_branch_cause: assert property ($rose(branch_out) |-> $past(sign_time_out) && $past(phase_h_out))
    else $error("branch set outside a shift sign time");
  a_early_recirc: assert property ((wp1 || wp2) && sign_time_out
    |=> $stable(upper_out) && $stable(lower_out))
    else $error("accumulators altered in word period 1 or 2");

  // ------------------------------------------------------------------
  // coverage of main scenarios
  // ------------------------------------------------------------------
  c_repeat: cover property (wp1 && sign_time_out && repeat_in);
  c_zero: cover property (wp2 && sign_time_out && zero);
  c_branch: cover property ($rose(branch_out));
  c_done: cover property (done_out);
endmodule // sass_shift_seq_properties

bind sass_shift_seq sass_shift_seq_properties #(.WORD_W(WORD_W), .COUNT_W(COUNT_W), .COUNT_LSB(COUNT_LSB))
  i_props (.clock_in(clock_in), .resetn_in(resetn_in), .repeat_in(repeat_in), .upper_out(upper_out),
  .lower_out(lower_out), .done_out(done_out), .branch_out(branch_out), .sign_time_out(sign_time_out),
  .phase_f_out(phase_f_out), .phase_g_out(phase_g_out), .phase_h_out(phase_h_out),
  .odd_even_out(odd_even_out), .count_out(count_out));

// File: test/testbench.sv
// self-checking bench for the shift sequencer
`timescale 1ns/1ns
module testbench;
  import sass_pkg::*;
  logic clock_in, resetn_in, acc_load_in, start_in, shift_left_in, repeat_in;
  logic [31:0] upper_load_in, lower_load_in, upper_out, lower_out;
  logic [5:0] shift_count_in, count_out;
  logic busy_out, done_out, branch_out, sign_time_out, phase_f_out, phase_g_out, phase_h_out, odd_even_out;
  int err_total;
  int n_compared;

  sass_shift_seq i_dut (.clock_in(clock_in), .resetn_in(resetn_in), .acc_load_in(acc_load_in),
    .upper_load_in(upper_load_in), .lower_load_in(lower_load_in), .start_in(start_in),
    .shift_left_in(shift_left_in), .shift_count_in(shift_count_in), .repeat_in(repeat_in),
    .upper_out(upper_out), .lower_out(lower_out), .busy_out(busy_out), .done_out(done_out),
    .branch_out(branch_out), .sign_time_out(sign_time_out), .phase_f_out(phase_f_out),
    .phase_g_out(phase_g_out), .phase_h_out(phase_h_out), .odd_even_out(odd_even_out), .count_out(count_out));

  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // left: first step feeds lower sign into upper, later steps the lower second bit
  function automatic logic [63:0] model(input logic left, input int n, input logic [63:0] v);
    logic [63:0] r;
    r = v;
    for (int k = 0; k < n; k++)
      r = left ? {r[62:32], (k == 0) ? r[31] : r[30], r[30:0], 1'b0} : {r[63], r[63:1]};
    return r;
  endfunction

  // ------------------------------------------------------------------
  // one shift command, preset in the same cycle as the start
  // ------------------------------------------------------------------
  task automatic run_shift(input string name, input logic left, input logic [5:0] n,
    input logic [31:0] u, input logic [31:0] l, input int rep, input logic exp_br);
    logic [63:0] exp;
    int signs;
    int cyc;
    int words;
    exp = model(left, n, {u, l});
    words = 7 + n + rep;
    signs = 0;
    if (sign_time_out === 1'b1)
    begin
      @(posedge clock_in);
      #1;
    end
    {acc_load_in, start_in, shift_left_in, shift_count_in, upper_load_in, lower_load_in} = {2'b11, left, n, u, l};
    @(posedge clock_in);
    #1;
    {acc_load_in, start_in} = 2'b00;
    chk({name, " busy"}, 32'h1, {31'h0, busy_out});
    for (cyc = 0; cyc < 4000 && done_out !== 1'b1; cyc++)
    begin
      repeat_in = (rep > 0) && phase_f_out && phase_g_out && !phase_h_out;
      // a start and a preset while busy must both be ignored
      {start_in, acc_load_in, shift_count_in, upper_load_in} = (cyc == 40) ? {2'b11, 6'h2a, 32'hffffffff}
        : {2'b00, n, u};
      @(posedge clock_in);
      if (sign_time_out === 1'b1)
        signs++;
      if (repeat_in && sign_time_out === 1'b1)
        rep--;
      #1;
    end
    repeat_in = 1'b0;
    if (cyc >= 4000)
    begin
      chk({name, " done"}, 32'h1, 32'h0);
      conclude();
    end
    chk({name, " upper"}, exp[63:32], upper_out);
    chk({name, " lower"}, exp[31:0], lower_out);
    chk({name, " branch"}, {31'h0, exp_br}, {31'h0, branch_out});
    chk({name, " idle"}, 32'h0, {31'h0, busy_out});
    if (n != 6'h00)
    begin
      chk({name, " words"}, words, signs);
      chk({name, " count"}, 32'h3f, {26'h0, count_out});
    end
    $display("%s finished", name);
  endtask

  task automatic test_reset();
    int k;
    chk("reset outputs", 32'h0, {upper_out[15:0], busy_out, done_out, branch_out, phase_f_out,
      phase_g_out, phase_h_out, odd_even_out, count_out});
    for (k = 0; k < 40 && sign_time_out !== 1'b1; k++)
    begin
      @(posedge clock_in);
      #1;
    end
    for (k = 1; k <= 32; k++)
    begin
      @(posedge clock_in);
      #1;
      chk("sign time", {31'h0, k == 32}, {31'h0, sign_time_out});
    end
    $display("reset and framing finished");
  endtask

  task automatic test_right_four();
    run_shift("right by 4", 1'b0, 6'h04, 32'h80000010, 32'h12345678, 0, 1'b0);
  endtask

  task automatic test_left_overflow();
    run_shift("left overflow", 1'b1, 6'h01, 32'h40000000, 32'h00000000, 0, 1'b1);
  endtask

  task automatic test_left_five();
    run_shift("left by 5", 1'b1, 6'h05, 32'h00000123, 32'h80000001, 0, 1'b0);
  endtask

  task automatic test_zero_count();
    run_shift("zero count", 1'b1, 6'h00, 32'h89abcdef, 32'h01234567, 0, 1'b0);
  endtask

  task automatic test_right_max();
    run_shift("right by 63", 1'b0, 6'h3f, 32'h80000001, 32'h00000000, 0, 1'b0);
  endtask

  task automatic test_repeat();
    run_shift("repeat held", 1'b0, 6'h02, 32'h00000f00, 32'h5a5a5a5a, 2, 1'b0);
  endtask

  initial
  begin
    err_total = 0;
    n_compared = 0;
    {resetn_in, acc_load_in, start_in, shift_left_in, repeat_in} = 5'h00;
    {shift_count_in, upper_load_in, lower_load_in} = '0;
    repeat (6) @(posedge clock_in);
    #1;
    resetn_in = 1'b1;
    test_reset();
    test_right_four();
    test_left_overflow();
    test_left_five();
    test_zero_count();
    test_right_max();
    test_repeat();
    conclude();
  end
endmodule // testbench
